// file: verilog/np_message_coder.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// R1 - selector names the base message type
// R2 - reserved selector values are never sent
// R3 - message code sets meaning of following pages
// R4 - reserved message codes are never sent
// R5 - all-zero message code is never sent
// R6 - all-one message code is never sent
// R7 - send null code while partner has pages
// R8 - remote fault followed by one page
// R9 - OUI message followed by four pages
// R10 - page one holds OUI 23:13, top-aligned
// R11 - page two holds OUI 12:2, top-aligned
// R12 - page three holds OUI 1:0 and user code
// R13 - page four holds only user code
// R14 - PHY page one holds word1 15:5
// R15 - PHY page two: word1 4:0, word2 15:10
// R16 - PHY page three: word2 9:0, user bit
// R17 - pages go in order, code held stable
module np_message_coder (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // base page selector
  input  wire logic [4:0]  base_sel_req,
  input  wire logic        base_sel_load,
  output logic [4:0]       base_selector,
  output logic             base_sel_reject,
  // message request
  input  wire logic        msg_req_valid,
  input  wire logic [1:0]  msg_req_kind,
  input  wire logic [10:0] raw_msg_code,
  output logic             msg_req_ready,
  output logic             msg_req_reject,
  // message contents
  input  wire logic [10:0] fault_type,
  input  wire logic [23:0] oui_value,
  input  wire logic [15:0] phy_identifier_value_word1,
  input  wire logic [15:0] phy_identifier_value_word2,
  input  wire logic [8:0]  oui_user_code,
  input  wire logic        phy_user_bit,
  input  wire logic [10:0] last_user_code,
  // next page exchange
  input  wire logic        np_active,
  input  wire logic        lp_pages_pending,
  input  wire logic        page_done,
  output logic             page_valid,
  output logic [10:0]      page_code,
  output logic             page_is_message,
  output logic             page_more,
  output logic [2:0]       page_index
);

  localparam int unsigned CW = np_coder_pkg::CODE_W;
  localparam int unsigned IW = np_coder_pkg::IDX_W;
  localparam int unsigned NP = np_coder_pkg::PAGE_SLOTS;

  // message code chosen for each kind
  function automatic logic [CW-1:0] kind_code(input logic [1:0] kind,
                                              input logic [CW-1:0] raw);
    logic [CW-1:0] c;
    c = raw;
    case (kind)
      np_coder_pkg::KIND_RF:  c = np_coder_pkg::MSG_CODE_RF;
      np_coder_pkg::KIND_OUI: c = np_coder_pkg::MSG_CODE_OUI;
      np_coder_pkg::KIND_PHY: c = np_coder_pkg::MSG_CODE_PHY;
      default:                c = raw;
    endcase
    return c;
  endfunction

  // number of unformatted pages after the message page
  function automatic logic [IW-1:0] unf_count(input logic [1:0] kind);
    logic [IW-1:0] n;
    n = np_coder_pkg::UNF_PAGES_RAW;
    case (kind)
      np_coder_pkg::KIND_RF:  n = np_coder_pkg::UNF_PAGES_RF;  // [R8]
      np_coder_pkg::KIND_OUI: n = np_coder_pkg::UNF_PAGES_ID;  // [R9]
      np_coder_pkg::KIND_PHY: n = np_coder_pkg::UNF_PAGES_ID;
      default:                n = np_coder_pkg::UNF_PAGES_RAW;
    endcase
    return n;
  endfunction

  // code field of page n of a message (page 0 is the message page)
  function automatic logic [CW-1:0] page_word(input logic [1:0]    kind,
                                              input logic [IW-1:0] n,
                                              input logic [CW-1:0] mcode);
    logic [CW-1:0] w;
    w = mcode;
    if (n != '0) begin
      w = last_user_code;  // [R13]
      case (kind)
        np_coder_pkg::KIND_RF: begin
          w = fault_type;  // [R8]
        end
        np_coder_pkg::KIND_OUI: begin
          if (n == 3'h1) begin
            w = oui_value[np_coder_pkg::OUI_P1_HI:np_coder_pkg::OUI_P1_LO];  // [R10]
          end else if (n == 3'h2) begin
            w = oui_value[np_coder_pkg::OUI_P2_HI:np_coder_pkg::OUI_P2_LO];  // [R11]
          end else if (n == 3'h3) begin
            w = {oui_value[1:0], oui_user_code};  // [R12]
          end
        end
        np_coder_pkg::KIND_PHY: begin
          if (n == 3'h1) begin
            w = phy_identifier_value_word1[15:np_coder_pkg::PHY_P1_LO];  // [R14]
          end else if (n == 3'h2) begin
            w = {phy_identifier_value_word1[4:0], phy_identifier_value_word2[15:10]};  // [R15]
          end else if (n == 3'h3) begin
            w = {phy_identifier_value_word2[9:0], phy_user_bit};  // [R16]
          end
        end
        default: begin
          w = mcode;
        end
      endcase
    end
    return w;
  endfunction

  // legality of requested selector and code
  logic          sel_legal;
  logic          code_legal;
  logic [CW-1:0] req_code;

  assign req_code = kind_code(msg_req_kind, raw_msg_code);

  np_code_check u_check (
    .selector   (base_sel_req),
    .msg_code   (req_code),
    .sel_legal  (sel_legal),
    .code_legal (code_legal)
  );

  // base page selector
  logic [4:0] base_sel_q;
  logic [4:0] base_sel_d;
  logic       sel_rej_q;
  logic       sel_rej_d;

  always_comb begin
    base_sel_d = base_sel_q;
    sel_rej_d  = 1'b0;
    if (base_sel_load) begin
      if (sel_legal) begin
        base_sel_d = base_sel_req;  // [R1]
      end else begin
        sel_rej_d = 1'b1;  // [R2]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      base_sel_q <= np_coder_pkg::SEL_ALLOCATED;
      sel_rej_q  <= 1'b0;
    end else begin
      base_sel_q <= base_sel_d;
      sel_rej_q  <= sel_rej_d;
    end
  end

  assign base_selector   = base_sel_q;
  assign base_sel_reject = sel_rej_q;

  // page sequencer; page contents snapshot at request so later
  // changes on the content inputs cannot disturb a message in flight
  np_coder_pkg::coder_state_e state_q;
  np_coder_pkg::coder_state_e state_d;
  logic [CW-1:0] pages_q [NP];
  logic [CW-1:0] pages_d [NP];
  logic [IW-1:0] last_q;
  logic [IW-1:0] last_d;
  logic [IW-1:0] idx_q;
  logic [IW-1:0] idx_d;
  logic          valid_q;
  logic          valid_d;
  logic [CW-1:0] code_q;
  logic [CW-1:0] code_d;
  logic          is_msg_q;
  logic          is_msg_d;
  logic          more_q;
  logic          more_d;
  logic          rej_q;
  logic          rej_d;
  logic [IW-1:0] next_idx;

  assign next_idx = idx_q + 3'h1;

  always_comb begin
    state_d  = state_q;
    pages_d  = pages_q;
    last_d   = last_q;
    idx_d    = idx_q;
    valid_d  = valid_q;
    code_d   = code_q;
    is_msg_d = is_msg_q;
    more_d   = more_q;
    rej_d    = 1'b0;
    case (state_q)
      np_coder_pkg::ST_IDLE: begin
        if (msg_req_valid) begin
          if (!code_legal) begin
            rej_d = 1'b1;  // [R4] [R5] [R6]
          end else begin
            for (int i = 0; i < NP; i++) begin
              pages_d[i] = page_word(msg_req_kind, IW'(i), req_code);  // [R3]
            end
            last_d   = unf_count(msg_req_kind);
            idx_d    = '0;
            code_d   = req_code;
            is_msg_d = 1'b1;
            more_d   = (unf_count(msg_req_kind) != '0);
            valid_d  = 1'b1;
            state_d  = np_coder_pkg::ST_SEND;
          end
        end else if (np_active && lp_pages_pending) begin
          code_d   = np_coder_pkg::MSG_CODE_NULL;  // [R7]
          is_msg_d = 1'b1;
          more_d   = 1'b0;
          idx_d    = '0;
          valid_d  = 1'b1;
          state_d  = np_coder_pkg::ST_NULL;
        end
      end
      np_coder_pkg::ST_SEND: begin
        // code stays put until the exchange for this page completes
        if (page_done) begin  // [R17]
          if (idx_q == last_q) begin
            valid_d = 1'b0;
            state_d = np_coder_pkg::ST_IDLE;
          end else begin
            idx_d    = next_idx;
            code_d   = pages_q[next_idx];  // [R17]
            is_msg_d = 1'b0;
            more_d   = (next_idx != last_q);
          end
        end
      end
      np_coder_pkg::ST_NULL: begin
        if (page_done) begin
          valid_d = 1'b0;
          state_d = np_coder_pkg::ST_IDLE;
        end
      end
      default: begin
        valid_d = 1'b0;
        state_d = np_coder_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q  <= np_coder_pkg::ST_IDLE;
      for (int i = 0; i < NP; i++) begin
        pages_q[i] <= np_coder_pkg::MSG_CODE_NULL;
      end
      last_q   <= '0;
      idx_q    <= '0;
      valid_q  <= 1'b0;
      code_q   <= np_coder_pkg::MSG_CODE_NULL;
      is_msg_q <= 1'b0;
      more_q   <= 1'b0;
      rej_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      pages_q  <= pages_d;
      last_q   <= last_d;
      idx_q    <= idx_d;
      valid_q  <= valid_d;
      code_q   <= code_d;
      is_msg_q <= is_msg_d;
      more_q   <= more_d;
      rej_q    <= rej_d;
    end
  end

  // a request is only looked at between messages
  assign msg_req_ready   = (state_q == np_coder_pkg::ST_IDLE);
  assign msg_req_reject  = rej_q;
  assign page_valid      = valid_q;
  assign page_code       = code_q;
  assign page_is_message = is_msg_q;
  assign page_more       = more_q;
  assign page_index      = idx_q;

endmodule

`default_nettype wire

// file: verilog/np_coder_pkg.sv
package np_coder_pkg;

  // field widths
  localparam int unsigned CODE_W  = 11;
  localparam int unsigned SEL_W   = 5;
  localparam int unsigned OUI_W   = 24;
  localparam int unsigned PHYID_W = 16;
  localparam int unsigned USER_W  = 9;
  localparam int unsigned IDX_W   = 3;
  localparam int unsigned KIND_W  = 2;

  // selector encoding; only this one value is allocated here
  localparam logic [4:0] SEL_ALLOCATED = 5'h01;

  // message codes
  localparam logic [10:0] MSG_CODE_ALL_ZERO  = 11'h000;
  localparam logic [10:0] MSG_CODE_ALL_ONE   = 11'h7FF;
  localparam logic [10:0] MSG_CODE_NULL      = 11'h001;
  localparam logic [10:0] MSG_CODE_RF        = 11'h004;
  localparam logic [10:0] MSG_CODE_OUI       = 11'h005;
  localparam logic [10:0] MSG_CODE_PHY       = 11'h006;
  localparam logic [10:0] MSG_CODE_LAST_USED = 11'h006;

  // pages sent after each message page
  localparam logic [2:0] UNF_PAGES_RF  = 3'h1;
  localparam logic [2:0] UNF_PAGES_ID  = 3'h4;
  localparam logic [2:0] UNF_PAGES_RAW = 3'h0;
  localparam int unsigned PAGE_SLOTS   = 5;

  // identifier slicing
  localparam int unsigned OUI_P1_HI = 23;
  localparam int unsigned OUI_P1_LO = 13;
  localparam int unsigned OUI_P2_HI = 12;
  localparam int unsigned OUI_P2_LO = 2;
  localparam int unsigned PHY_P1_LO = 5;

  // requested message kind
  typedef enum logic [1:0] {
    KIND_RF  = 2'b00,
    KIND_OUI = 2'b01,
    KIND_PHY = 2'b10,
    KIND_RAW = 2'b11
  } msg_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_NULL = 2'b10
  } coder_state_e;

endpackage

// file: verilog/np_code_check.sv
`timescale 1ns/10ps
`default_nettype none

// judges selector and message code values before they may go out
module np_code_check (
  // values under test
  input  wire logic [4:0]  selector,
  input  wire logic [10:0] msg_code,
  // verdicts
  output logic             sel_legal,
  output logic             code_legal
);

  always_comb begin
    sel_legal  = (selector == np_coder_pkg::SEL_ALLOCATED);
    code_legal = 1'b1;
    if (msg_code == np_coder_pkg::MSG_CODE_ALL_ZERO) begin
      code_legal = 1'b0;
    end else if (msg_code == np_coder_pkg::MSG_CODE_ALL_ONE) begin
      code_legal = 1'b0;
    end else if (msg_code > np_coder_pkg::MSG_CODE_LAST_USED) begin
      code_legal = 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: sim/np_coder_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module np_coder_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // requests
  input wire logic        base_sel_load,
  input wire logic        msg_req_valid,
  input wire logic        np_active,
  input wire logic        lp_pages_pending,
  input wire logic        page_done,
  input wire logic [4:0]  base_sel_req,
  input wire logic [1:0]  msg_req_kind,
  input wire logic [10:0] raw_msg_code,
  // coder outputs
  input wire logic [4:0]  base_selector,
  input wire logic        base_sel_reject,
  input wire logic        msg_req_ready,
  input wire logic        msg_req_reject,
  input wire logic        page_valid,
  input wire logic        page_is_message,
  input wire logic        page_more,
  input wire logic [10:0] page_code,
  input wire logic [2:0]  page_index
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sel_refuse_a: assert property (base_sel_load && base_sel_req != 5'h01 |=>
    base_sel_reject && $stable(base_selector)) else $error("bad selector taken");
  sel_value_a: assert property (base_selector == np_coder_pkg::SEL_ALLOCATED)
    else $error("selector not allocated");
  code_zero_a: assert property (page_valid && page_is_message |-> page_code != 11'h000)
    else $error("all-zero code sent");
  code_ones_a: assert property (page_valid && page_is_message |-> page_code != 11'h7FF)
    else $error("all-one code sent");
  code_resv_a: assert property (page_valid && page_is_message |-> page_code <= 11'h006)
    else $error("reserved code sent");
  null_page_a: assert property (np_active && lp_pages_pending && msg_req_ready
    && !msg_req_valid && !page_valid |=> page_valid && page_code == 11'h001 && page_is_message)
    else $error("null page missing");
  hold_page_a: assert property (page_valid && !page_done |=>
    page_valid && $stable(page_code) && $stable(page_index)) else $error("page changed early");
  next_index_a: assert property (page_valid && page_done && page_more |=>
    page_valid && page_index == $past(page_index) + 3'h1) else $error("page order broken");
  last_page_a: assert property (page_valid && page_done && !page_more |=>
    !page_valid && msg_req_ready) else $error("extra page after last");
  req_reject_a: assert property (msg_req_valid && msg_req_ready && msg_req_kind == 2'h3
    && (raw_msg_code == 11'h000 || raw_msg_code > 11'h006) |=> msg_req_reject && !page_valid)
    else $error("illegal code not refused");
  oui_start_a: assert property (msg_req_valid && msg_req_ready && msg_req_kind == 2'h1
    |=> page_valid && page_code == 11'h005 && page_more && page_index == 3'h0)
    else $error("identifier page wrong");
endmodule
bind np_message_coder np_coder_asserts i_np_coder_asserts (
  .clk              (clk),
  .rst              (rst),
  .base_sel_load    (base_sel_load),
  .msg_req_valid    (msg_req_valid),
  .np_active        (np_active),
  .lp_pages_pending (lp_pages_pending),
  .page_done        (page_done),
  .base_sel_req     (base_sel_req),
  .msg_req_kind     (msg_req_kind),
  .raw_msg_code     (raw_msg_code),
  .base_selector    (base_selector),
  .base_sel_reject  (base_sel_reject),
  .msg_req_ready    (msg_req_ready),
  .msg_req_reject   (msg_req_reject),
  .page_valid       (page_valid),
  .page_is_message  (page_is_message),
  .page_more        (page_more),
  .page_code        (page_code),
  .page_index       (page_index)
);
`default_nettype wire

// file: sim/np_link_partner.sv
`timescale 1ns/10ps
`default_nettype none
// far-side negotiator: acknowledges each presented page after a delay
module np_link_partner (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // page from the coder
  input  wire logic        page_valid,
  input  wire logic [10:0] page_code,
  input  wire logic [3:0]  delay,
  output logic             page_done
);
  logic [10:0] log_q [0:63];
  int          n_q;
  logic [3:0]  cnt_q;
  // skip the cycle after an ack: the next page only shows then
  always_ff @(posedge clk) begin
    page_done <= 1'b0;
    if (rst) begin
      cnt_q <= 4'h0;
      n_q   <= 0;
    end else if (page_valid && !page_done) begin
      if (cnt_q == delay) begin
        page_done  <= 1'b1;
        log_q[n_q] <= page_code;
        n_q        <= n_q + 1;
        cnt_q      <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk = 1'b0, rst = 1'b1, base_sel_load = 1'b0, msg_req_valid = 1'b0;
  logic        np_active = 1'b0, lp_pages_pending = 1'b0, phy_user_bit = 1'b0;
  logic [4:0]  base_sel_req = 5'h01;
  logic [1:0]  msg_req_kind = 2'h0;
  logic [10:0] raw_msg_code = 11'h001, fault_type = 11'h000, last_user_code = 11'h000;
  logic [23:0] oui_value = 24'h000000;
  logic [15:0] phy_identifier_value_word1 = 16'h0000, phy_identifier_value_word2 = 16'h0000;
  logic [8:0]  oui_user_code = 9'h000;
  logic [3:0]  delay = 4'h0;
  logic [4:0]  base_selector;
  logic        base_sel_reject, msg_req_ready, msg_req_reject, page_done;
  logic        page_valid, page_is_message, page_more;
  logic [10:0] page_code;
  logic [2:0]  page_index;
  int          err_total = 0, compares = 0, base_n = 0;

  np_message_coder i_np_message_coder (
    .clk              (clk),
    .rst              (rst),
    .base_sel_req     (base_sel_req),
    .base_sel_load    (base_sel_load),
    .base_selector    (base_selector),
    .base_sel_reject  (base_sel_reject),
    .msg_req_valid    (msg_req_valid),
    .msg_req_kind     (msg_req_kind),
    .raw_msg_code     (raw_msg_code),
    .msg_req_ready    (msg_req_ready),
    .msg_req_reject   (msg_req_reject),
    .fault_type       (fault_type),
    .oui_value        (oui_value),
    .phy_identifier_value_word1     (phy_identifier_value_word1),
    .phy_identifier_value_word2     (phy_identifier_value_word2),
    .oui_user_code    (oui_user_code),
    .phy_user_bit     (phy_user_bit),
    .last_user_code   (last_user_code),
    .np_active        (np_active),
    .lp_pages_pending (lp_pages_pending),
    .page_done        (page_done),
    .page_valid       (page_valid),
    .page_code        (page_code),
    .page_is_message  (page_is_message),
    .page_more        (page_more),
    .page_index       (page_index)
  );
  np_link_partner  i_np_link_partner (
    .clk        (clk),
    .rst        (rst),
    .page_valid (page_valid),
    .page_code  (page_code),
    .delay      (delay),
    .page_done  (page_done)
  );

  always #5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [10:0] pg(input int i);
    return i_np_link_partner.log_q[base_n + i];
  endfunction

  task automatic wait_idle();
    for (int k = 0; !(msg_req_ready === 1'b1 && page_valid === 1'b0); k++) begin
      if (k > 300) begin
        err_total++;
        report_and_stop();
      end
      @(negedge clk);
    end
  endtask

  task automatic send(input logic [1:0] kind, input int pages);
    base_n = i_np_link_partner.n_q;
    msg_req_kind = kind;
    msg_req_valid = 1'b1;
    @(negedge clk);
    msg_req_valid = 1'b0;
    check(msg_req_ready, 1'b0);
    check(page_valid, 1'b1);
    check(page_is_message, 1'b1);
    check(page_index, 3'h0);
    check(page_more, pages > 1);
    wait_idle();
    check(i_np_link_partner.n_q - base_n, pages);
  endtask

  task automatic sc_selector();
    logic [4:0] v [4] = '{5'h02, 5'h00, 5'h1F, 5'h01};
    foreach (v[i]) begin
      base_sel_req = v[i];
      base_sel_load = 1'b1;
      @(negedge clk);
      base_sel_load = 1'b0;
      check(base_sel_reject, v[i] != 5'h01);
      check(base_selector, 5'h01);
      @(negedge clk);
    end
  endtask

  task automatic sc_fault();
    fault_type = 11'h2B6;
    send(2'h0, 2);
    check(pg(0), 11'h004);
    check(pg(1), fault_type);
  endtask

  task automatic sc_oui();
    oui_value = 24'hA5C3E1;
    oui_user_code = 9'h15A;
    last_user_code = 11'h3C7;
    send(2'h1, 5);
    check(pg(0), 11'h005);
    check(pg(1), oui_value[23:13]);
    check(pg(2), oui_value[12:2]);
    check(pg(3), {oui_value[1:0], oui_user_code});
    check(pg(4), last_user_code);
  endtask

  task automatic sc_phy();
    phy_identifier_value_word1 = 16'hB2D4;
    phy_identifier_value_word2 = 16'h69E1;
    phy_user_bit = 1'b1;
    last_user_code = 11'h155;
    delay = 4'h5;
    send(2'h2, 5);
    delay = 4'h0;
    check(pg(0), 11'h006);
    check(pg(1), phy_identifier_value_word1[15:5]);
    check(pg(2), {phy_identifier_value_word1[4:0], phy_identifier_value_word2[15:10]});
    check(pg(3), {phy_identifier_value_word2[9:0], phy_user_bit});
    check(pg(4), last_user_code);
  endtask

  task automatic sc_reject();
    logic [10:0] bad [3] = '{11'h000, 11'h7FF, 11'h007};
    foreach (bad[i]) begin
      raw_msg_code = bad[i];
      msg_req_kind = 2'h3;
      msg_req_valid = 1'b1;
      @(negedge clk);
      msg_req_valid = 1'b0;
      check(msg_req_reject, 1'b1);
      check(page_valid, 1'b0);
      @(negedge clk);
    end
    raw_msg_code = 11'h003;
    send(2'h3, 1);
    check(pg(0), 11'h003);
  endtask

  task automatic sc_null();
    base_n = i_np_link_partner.n_q;
    np_active = 1'b1;
    lp_pages_pending = 1'b1;
    for (int k = 0; k < 50 && i_np_link_partner.n_q < base_n + 2; k++) begin
      @(negedge clk);
    end
    // a null exchange that never completes is a timeout
    if (i_np_link_partner.n_q < base_n + 2) begin
      err_total++;
      report_and_stop();
    end
    np_active = 1'b0;
    lp_pages_pending = 1'b0;
    wait_idle();
    check(pg(0), 11'h001);
    check(pg(1), 11'h001);
  endtask

  // reset in the middle of a message, then a clean message after it
  task automatic sc_reset();
    fault_type = 11'h1C3;
    msg_req_kind = 2'h0;
    msg_req_valid = 1'b1;
    @(negedge clk);
    msg_req_valid = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check(page_valid, 1'b0);
    check(page_code, 11'h001);
    check(page_is_message, 1'b0);
    check(page_more, 1'b0);
    check(page_index, 3'h0);
    check(msg_req_ready, 1'b1);
    check(base_selector, 5'h01);
    rst = 1'b0;
    send(2'h0, 2);
    check(pg(0), 11'h004);
    check(pg(1), fault_type);
  endtask

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    sc_selector();
    sc_fault();
    sc_oui();
    sc_phy();
    sc_reject();
    sc_null();
    sc_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
